// file: rtl/adc_fe_cal_pkg.sv
// Offsets, field positions, reset values and timing constants of the front-end config bank
package adc_fe_cal_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [11:0] OFS_FRONT_END_INPUT_CONFIG  = 12'hBA2;
    localparam logic [11:0] OFS_CALIBRATION_CLOCK_GATE  = 12'hBB3;
    localparam logic [11:0] OFS_CAL_GAIN_BYTE_LOW       = 12'hBBA;
    localparam logic [11:0] OFS_CAL_GAIN_BYTE_MID       = 12'hBBB;
    localparam logic [11:0] OFS_CAL_GAIN_BYTE_HIGH      = 12'hBBC;
    localparam logic [11:0] OFS_CENTRE_OFFSET           = 12'hBC3;
    localparam logic [11:0] OFS_CAP_MEASURE_WAIT_COUNT  = 12'hBC8;
    localparam logic [11:0] OFS_TEMPERATURE_DIODE_TRIM  = 12'hC01;
    localparam logic [11:0] OFS_REFERENCE_MONITOR_SEL   = 12'hC04;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0]  RST_REGISTER                = 8'h00;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int          BIT_FORCE_CM                = 7;
    localparam int          BIT_HIGH_IMP                = 6;
    localparam int          TERM_MSB                    = 5;
    localparam int          TERM_LSB                    = 4;
    localparam int          BIT_CAL_CLK_EN              = 7;
    localparam int          GAIN_HIGH_MSB               = 5;
    localparam int          CENTRE_MSB                  = 7;
    localparam int          CENTRE_LSB                  = 2;
    localparam int          MON_MSB                     = 3;
    localparam int          MON_LSB                     = 2;

    // Writable masks; cleared bits are read-only reserved and read as zero
    localparam logic [7:0]  MASK_GAIN_HIGH              = 8'h3F;
    localparam logic [7:0]  MASK_CENTRE                 = 8'hFC;
    localparam logic [7:0]  MASK_MONITOR                = 8'h0F;

    // ****************************************************************
    // Field encodings
    // ****************************************************************
    localparam logic [7:0]  TRIM_SENSE_BOTH             = 8'h03;
    localparam logic [1:0]  MON_DEFAULT                 = 2'h0;
    localparam logic [1:0]  MON_DIODE_1X                = 2'h1;
    localparam logic [1:0]  MON_DIODE_20X               = 2'h2;
    localparam logic [1:0]  MON_GROUND                  = 2'h3;

    // ****************************************************************
    // Ramp timing: one wait step is one period of the fs/8 clock
    // ****************************************************************
    localparam int          RAMP_DIV                    = 8;
    localparam int          RAMP_PHASE_W                = 3;
    localparam logic [2:0]  RAMP_PHASE_LAST             = 3'h7;
    localparam logic [7:0]  WAIT_COUNT_MIN              = 8'h7D;
    localparam logic [7:0]  WAIT_COUNT_MAX              = 8'hFF;

endpackage : adc_fe_cal_pkg

// file: rtl/cap_ramp_timer.sv
// Capacitance-measurement ramp delay timer counting in fs/8 clock periods
`timescale 1ns/1ps
`default_nettype none

module cap_ramp_timer (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Measurement control
    input  wire logic        cap_reset,
    input  wire logic [7:0]  wait_count,
    // Ramp clock
    output var  logic        ramp_clk
);

    logic                                    cap_reset_q;
    logic                                    counting;
    logic [adc_fe_cal_pkg::RAMP_PHASE_W-1:0] phase;
    logic [7:0]                              remaining;
    wire                                     reset_fall;
    wire                                     step_done;

    assign reset_fall = cap_reset_q & ~cap_reset;
    assign step_done  = counting && (phase == adc_fe_cal_pkg::RAMP_PHASE_LAST);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cap_reset_q <= 1'b0;
        end else begin
            cap_reset_q <= cap_reset;
        end
    end

    // ****************************************************************
    // Delay from reset fall to ramp fall is wait_count fs/8 periods
    // ****************************************************************
    // Divider restarts at the edge so the delay is exact, not off by a phase
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            counting  <= 1'b0;
            phase     <= '0;
            remaining <= 8'h00;
            ramp_clk  <= 1'b0;
        end else if (cap_reset) begin
            counting  <= 1'b0;
            phase     <= '0;
            ramp_clk  <= 1'b1;
        end else if (reset_fall) begin
            counting  <= (wait_count != 8'h00);
            phase     <= '0;
            remaining <= wait_count;
            ramp_clk  <= (wait_count != 8'h00);
        end else if (counting) begin
            phase <= phase + {{(adc_fe_cal_pkg::RAMP_PHASE_W - 1){1'b0}}, 1'b1};
            if (step_done) begin
                remaining <= remaining - 8'h01;
                if (remaining == 8'h01) begin
                    counting <= 1'b0;
                    ramp_clk <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [10:0] elapsed;
    logic [7:0]  wait_latched;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            elapsed      <= 11'h000;
            wait_latched <= 8'h00;
        end else if (reset_fall) begin
            elapsed      <= 11'h000;
            wait_latched <= wait_count;
        end else begin
            elapsed <= elapsed + 11'h001;
        end
    end

    ramp_delay_a: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(ramp_clk) && !$past(cap_reset) && !$past(reset_fall)
            |-> elapsed == {wait_latched, 3'h0})
        else $error("ramp clock fell at the wrong delay");

    ramp_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        reset_fall && wait_count == 8'h7D && !cap_reset
            |=> (ramp_clk && !cap_reset) [*8] or cap_reset)
        else $error("ramp clock dropped early");

    ramp_fall_c: cover property (@(posedge clk) disable iff (!reset_n)
        counting ##1 $fell(ramp_clk));

endmodule : cap_ramp_timer

`default_nettype wire

// file: rtl/adc_front_end_cal_config_regs.sv
// Front-end, calibration and temperature-sensing configuration register bank
`timescale 1ns/1ps
`default_nettype none

module adc_front_end_cal_config_regs (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Register access from the serial control port
    input  wire logic [11:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output var  logic [7:0]  reg_rdata,
    output var  logic        reg_rvalid,
    // Front end
    output var  logic        common_mode_forcing,
    output var  logic        cm_high_impedance,
    output var  logic [1:0]  input_termination_select,
    // Calibration
    output var  logic        cal_clk_enable,
    output var  logic [21:0] cal_gain_constant,
    output var  logic [5:0]  centre_offset_value,
    // Capacitance measurement ramp
    input  wire logic        cap_reset,
    output var  logic        ramp_clk,
    // Temperature sensing
    output var  logic        diode_sense_enable,
    output var  logic        mon_diode_1x,
    output var  logic        mon_diode_20x,
    output var  logic        mon_ground
);

    default clocking check_clk @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [7:0] front_end_input_config;
    logic [7:0] calibration_clock_gate;
    logic [7:0] cal_gain_byte_low;
    logic [7:0] cal_gain_byte_mid;
    logic [7:0] cal_gain_byte_high;
    logic [7:0] centre_offset;
    logic [7:0] cap_measure_wait_count;
    logic [7:0] temperature_diode_trim;
    logic [7:0] reference_monitor_select;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    wire sel_fe    = (reg_addr == adc_fe_cal_pkg::OFS_FRONT_END_INPUT_CONFIG);
    wire sel_cal   = (reg_addr == adc_fe_cal_pkg::OFS_CALIBRATION_CLOCK_GATE);
    wire sel_g_lo  = (reg_addr == adc_fe_cal_pkg::OFS_CAL_GAIN_BYTE_LOW);
    wire sel_g_mid = (reg_addr == adc_fe_cal_pkg::OFS_CAL_GAIN_BYTE_MID);
    wire sel_g_hi  = (reg_addr == adc_fe_cal_pkg::OFS_CAL_GAIN_BYTE_HIGH);
    wire sel_ctr   = (reg_addr == adc_fe_cal_pkg::OFS_CENTRE_OFFSET);
    wire sel_wait  = (reg_addr == adc_fe_cal_pkg::OFS_CAP_MEASURE_WAIT_COUNT);
    wire sel_trim  = (reg_addr == adc_fe_cal_pkg::OFS_TEMPERATURE_DIODE_TRIM);
    wire sel_mon   = (reg_addr == adc_fe_cal_pkg::OFS_REFERENCE_MONITOR_SEL);
    wire any_sel   = sel_fe | sel_cal | sel_g_lo | sel_g_mid | sel_g_hi | sel_ctr
                   | sel_wait | sel_trim | sel_mon;

    // An unmapped offset enables no register, so its write is dropped
    wire wr_fe     = reg_wr & sel_fe;
    wire wr_cal    = reg_wr & sel_cal;
    wire wr_g_lo   = reg_wr & sel_g_lo;
    wire wr_g_mid  = reg_wr & sel_g_mid;
    wire wr_g_hi   = reg_wr & sel_g_hi;
    wire wr_ctr    = reg_wr & sel_ctr;
    wire wr_wait   = reg_wr & sel_wait;
    wire wr_trim   = reg_wr & sel_trim;
    wire wr_mon    = reg_wr & sel_mon;

    // Unmapped addresses read as zero and swallow writes
    wire [7:0] read_mux =
        sel_fe    ? front_end_input_config   :
        sel_cal   ? calibration_clock_gate   :
        sel_g_lo  ? cal_gain_byte_low        :
        sel_g_mid ? cal_gain_byte_mid        :
        sel_g_hi  ? cal_gain_byte_high       :
        sel_ctr   ? centre_offset            :
        sel_wait  ? cap_measure_wait_count   :
        sel_trim  ? temperature_diode_trim   :
        sel_mon   ? reference_monitor_select : 8'h00;

    // Read-only reserved bits are masked on the way in, so they stay zero
    wire [7:0] wdata_g_hi = reg_wdata & adc_fe_cal_pkg::MASK_GAIN_HIGH;
    wire [7:0] wdata_ctr  = reg_wdata & adc_fe_cal_pkg::MASK_CENTRE;
    wire [7:0] wdata_mon  = reg_wdata & adc_fe_cal_pkg::MASK_MONITOR;

    wire [1:0] mon_field  = reference_monitor_select[adc_fe_cal_pkg::MON_MSB:
                                                     adc_fe_cal_pkg::MON_LSB];
    wire       next_sense = (temperature_diode_trim == adc_fe_cal_pkg::TRIM_SENSE_BOTH);

    // ****************************************************************
    // Register writes
    // ****************************************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            front_end_input_config   <= adc_fe_cal_pkg::RST_REGISTER;
            calibration_clock_gate   <= adc_fe_cal_pkg::RST_REGISTER;
            cal_gain_byte_low        <= adc_fe_cal_pkg::RST_REGISTER;
            cal_gain_byte_mid        <= adc_fe_cal_pkg::RST_REGISTER;
            cal_gain_byte_high       <= adc_fe_cal_pkg::RST_REGISTER;
            centre_offset            <= adc_fe_cal_pkg::RST_REGISTER;
            cap_measure_wait_count   <= adc_fe_cal_pkg::RST_REGISTER;
            temperature_diode_trim   <= adc_fe_cal_pkg::RST_REGISTER;
            reference_monitor_select <= adc_fe_cal_pkg::RST_REGISTER;
        end else begin
            if (wr_fe)     front_end_input_config   <= reg_wdata;
            if (wr_cal)    calibration_clock_gate   <= reg_wdata;
            if (wr_g_lo)   cal_gain_byte_low        <= reg_wdata;
            if (wr_g_mid)  cal_gain_byte_mid        <= reg_wdata;
            if (wr_g_hi)   cal_gain_byte_high       <= wdata_g_hi;
            if (wr_ctr)    centre_offset            <= wdata_ctr;
            if (wr_wait)   cap_measure_wait_count   <= reg_wdata;
            if (wr_trim)   temperature_diode_trim   <= reg_wdata;
            if (wr_mon)    reference_monitor_select <= wdata_mon;
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    // Read-only bits of the addressed register, for the reserved-bit check
    wire [7:0] ro_bits =
        sel_g_hi ? ~adc_fe_cal_pkg::MASK_GAIN_HIGH :
        sel_ctr  ? ~adc_fe_cal_pkg::MASK_CENTRE    :
        sel_mon  ? ~adc_fe_cal_pkg::MASK_MONITOR   : 8'h00;

    // A read in the same cycle as a write returns the old contents
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= read_mux;
            end
        end
    end

    // ****************************************************************
    // Control outputs
    // ****************************************************************
    assign common_mode_forcing      = front_end_input_config[adc_fe_cal_pkg::BIT_FORCE_CM];
    assign cm_high_impedance        = front_end_input_config[adc_fe_cal_pkg::BIT_HIGH_IMP];
    assign input_termination_select = front_end_input_config[adc_fe_cal_pkg::TERM_MSB:
                                                             adc_fe_cal_pkg::TERM_LSB];
    assign cal_clk_enable           = calibration_clock_gate[adc_fe_cal_pkg::BIT_CAL_CLK_EN];
    assign cal_gain_constant        = {cal_gain_byte_high[adc_fe_cal_pkg::GAIN_HIGH_MSB:0],
                                       cal_gain_byte_mid, cal_gain_byte_low};
    assign centre_offset_value      = centre_offset[adc_fe_cal_pkg::CENTRE_MSB:
                                                    adc_fe_cal_pkg::CENTRE_LSB];

    // Decoded temperature controls get their own flops to stay glitch free
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            diode_sense_enable <= 1'b0;
            mon_diode_1x       <= 1'b0;
            mon_diode_20x      <= 1'b0;
            mon_ground         <= 1'b0;
        end else begin
            diode_sense_enable <= next_sense;
            mon_diode_1x       <= (mon_field == adc_fe_cal_pkg::MON_DIODE_1X);
            mon_diode_20x      <= (mon_field == adc_fe_cal_pkg::MON_DIODE_20X);
            mon_ground         <= (mon_field == adc_fe_cal_pkg::MON_GROUND);
        end
    end

    // ****************************************************************
    // Ramp timer
    // ****************************************************************
    // Counts whatever is programmed; staying within 125..255 is left to software
    cap_ramp_timer i_cap_ramp_timer (
        .clk        (clk),
        .reset_n    (reset_n),
        .cap_reset  (cap_reset),
        .wait_count (cap_measure_wait_count),
        .ramp_clk   (ramp_clk)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    force_cm_a: assert property (@(posedge clk) disable iff (!reset_n)
        reg_wr && sel_fe |=> common_mode_forcing == $past(reg_wdata[7]))
        else $error("common-mode forcing does not follow the write");

    high_imp_a: assert property (@(posedge clk) disable iff (!reset_n)
        reg_wr && sel_fe |=> cm_high_impedance == $past(reg_wdata[6]))
        else $error("high-impedance control does not follow the write");

    cal_clock_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        reg_wr && sel_cal |=> cal_clk_enable == $past(reg_wdata[7]))
        else $error("calibration clock gate does not follow the write");

    gain_high_byte_a: assert property (@(posedge clk) disable iff (!reset_n)
        reg_wr && sel_g_hi |=> cal_gain_constant[21:16] == $past(reg_wdata[5:0])
            && $stable(cal_gain_constant[15:0]))
        else $error("gain constant high part misplaced");

    gain_mid_byte_a: assert property (@(posedge clk) disable iff (!reset_n)
        reg_wr && sel_g_mid |=> cal_gain_constant[15:8] == $past(reg_wdata))
        else $error("gain constant middle byte misplaced");

    centre_value_a: assert property (@(posedge clk) disable iff (!reset_n)
        reg_wr && sel_ctr |=> centre_offset_value == $past(reg_wdata[7:2]))
        else $error("centre offset misplaced");

    reserved_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        reg_rd |=> reg_rvalid && (reg_rdata & $past(ro_bits)) == 8'h00)
        else $error("read-only reserved bits read nonzero");

    trim_sense_a: assert property (@(posedge clk) disable iff (!reset_n)
        reg_wr && sel_trim |-> ##2 diode_sense_enable == ($past(reg_wdata, 2) == 8'h03))
        else $error("diode sensing does not match the trim value");

    monitor_route_a: assert property (@(posedge clk) disable iff (!reset_n)
        reg_wr && sel_mon |-> ##2
            {mon_diode_1x, mon_diode_20x, mon_ground} ==
            {$past(reg_wdata[3:2], 2) == 2'h1, $past(reg_wdata[3:2], 2) == 2'h2,
             $past(reg_wdata[3:2], 2) == 2'h3})
        else $error("monitor routing wrong for the select value");

    // Storage, output fields, read path, reserved bits, monitor decode and ramp preset
    term_select_a: assert property (wr_fe |=> input_termination_select == $past(reg_wdata[5:4]))
        else $error("termination select wrong");

    gain_low_byte_a: assert property (wr_g_lo |=> cal_gain_constant[7:0] == $past(reg_wdata))
        else $error("gain constant low byte misplaced");

    fe_store_a: assert property (wr_fe |=> front_end_input_config == $past(reg_wdata))
        else $error("front-end register not stored");

    wait_store_a: assert property (wr_wait |=> cap_measure_wait_count == $past(reg_wdata))
        else $error("wait count not stored");

    reserved_store_a: assert property (cal_gain_byte_high[7:6] == 2'h0
            && centre_offset[1:0] == 2'h0 && reference_monitor_select[7:4] == 4'h0)
        else $error("read-only reserved bit set");

    unmapped_write_a: assert property (reg_wr && !any_sel |=> $stable({
            front_end_input_config, calibration_clock_gate, cal_gain_byte_low,
            cal_gain_byte_mid, cal_gain_byte_high, centre_offset, cap_measure_wait_count,
            temperature_diode_trim, reference_monitor_select}))
        else $error("unmapped write changed a register");

    read_pulse_a: assert property (reg_rvalid == $past(reg_rd))
        else $error("read valid not one cycle after the read");

    read_data_a: assert property (reg_rd |=> reg_rdata == $past(read_mux))
        else $error("read data not the addressed register");

    unmapped_read_a: assert property (reg_rd && !any_sel |=> reg_rdata == 8'h00)
        else $error("unmapped address read nonzero");

    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    monitor_onehot_a: assert property ($onehot0({mon_diode_1x, mon_diode_20x, mon_ground}))
        else $error("several monitor routes selected");

    ramp_preset_a: assert property (cap_reset |=> ramp_clk)
        else $error("ramp clock low during measurement reset");

    trim_sense_c: cover property (@(posedge clk) disable iff (!reset_n)
        reg_wr && sel_trim && reg_wdata == 8'h03 ##2 diode_sense_enable);

    diode_20x_c: cover property (@(posedge clk) disable iff (!reset_n)
        diode_sense_enable && mon_diode_20x);

    gain_read_c: cover property (@(posedge clk) disable iff (!reset_n)
        reg_rd && sel_g_hi ##1 reg_rvalid);

    monitor_1x_c: cover property (
        wr_mon ##2 mon_diode_1x);

endmodule : adc_front_end_cal_config_regs

`default_nettype wire

// file: tb/adc_front_end_cal_config_regs_tb.sv
// Self-checking testbench of the front-end calibration configuration bank
`timescale 1ns/1ps
`default_nettype none

module adc_front_end_cal_config_regs_tb;
    // ****************************************************************
    // Signals and bookkeeping
    // ****************************************************************
    logic        clk;
    logic        reset_n;
    logic [11:0] reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic        reg_rvalid;
    logic        common_mode_forcing;
    logic        cm_high_impedance;
    logic [1:0]  input_termination_select;
    logic        cal_clk_enable;
    logic [21:0] cal_gain_constant;
    logic [5:0]  centre_offset_value;
    logic        cap_reset;
    logic        ramp_clk;
    logic        diode_sense_enable;
    logic        mon_diode_1x;
    logic        mon_diode_20x;
    logic        mon_ground;
    int          mismatches;
    int          n_checks;
    int          cycles;
    int          n;
    logic [7:0]  d;
    logic [7:0]  got;
    logic [7:0]  shadow [9];
    logic [11:0] addrs  [9];

    adc_front_end_cal_config_regs i_adc_front_end_cal_config_regs (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .common_mode_forcing(common_mode_forcing), .cm_high_impedance(cm_high_impedance),
        .input_termination_select(input_termination_select), .cal_clk_enable(cal_clk_enable),
        .cal_gain_constant(cal_gain_constant), .centre_offset_value(centre_offset_value),
        .cap_reset(cap_reset), .ramp_clk(ramp_clk), .diode_sense_enable(diode_sense_enable),
        .mon_diode_1x(mon_diode_1x), .mon_diode_20x(mon_diode_20x), .mon_ground(mon_ground)
    );

    // ****************************************************************
    // Expectations, bus cycles and comparisons
    // ****************************************************************
    function automatic logic [7:0] mask_of(input int i);
        case (i)
            4: mask_of = adc_fe_cal_pkg::MASK_GAIN_HIGH;
            5: mask_of = adc_fe_cal_pkg::MASK_CENTRE;
            8: mask_of = adc_fe_cal_pkg::MASK_MONITOR;
            default: mask_of = 8'hFF;
        endcase
    endfunction : mask_of

    // One-hot {ground, 20x, 1x}; the default code selects nothing
    function automatic logic [2:0] mon_exp(input logic [1:0] s);
        mon_exp = 3'((4'h1 << s) >> 1);
    endfunction : mon_exp

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Idle cycle after each strobe so a strobe is never lowered and raised in one step
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(posedge clk) #1;
        reg_wr = 1'b0;
        @(posedge clk) #1;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [7:0] v);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk) #1;
        reg_rd = 1'b0;
        chk("rvalid high", 32'h1, reg_rvalid);
        v = reg_rdata;
        @(posedge clk) #1;
        chk("rvalid low", 32'h0, reg_rvalid);
    endtask : rd

    task automatic check_outs;
        @(posedge clk) #1;
        chk("force_cm", shadow[0][7], common_mode_forcing);
        chk("high_imp", shadow[0][6], cm_high_impedance);
        chk("termination", shadow[0][5:4], input_termination_select);
        chk("cal_clk", shadow[1][7], cal_clk_enable);
        chk("gain", {shadow[4][5:0], shadow[3], shadow[2]}, cal_gain_constant);
        chk("centre", shadow[5][7:2], centre_offset_value);
        chk("sense", shadow[7] == adc_fe_cal_pkg::TRIM_SENSE_BOTH, diode_sense_enable);
        chk("monitor", mon_exp(shadow[8][3:2]), {mon_ground, mon_diode_20x, mon_diode_1x});
    endtask : check_outs

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Ramp waits dominate the run at a few thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end

    initial begin
        {reset_n, reg_addr, reg_wr, reg_rd, reg_wdata, cap_reset} = '0;
        {mismatches, n_checks, cycles} = '0;
        addrs = '{adc_fe_cal_pkg::OFS_FRONT_END_INPUT_CONFIG, adc_fe_cal_pkg::OFS_CALIBRATION_CLOCK_GATE,
                  adc_fe_cal_pkg::OFS_CAL_GAIN_BYTE_LOW, adc_fe_cal_pkg::OFS_CAL_GAIN_BYTE_MID,
                  adc_fe_cal_pkg::OFS_CAL_GAIN_BYTE_HIGH, adc_fe_cal_pkg::OFS_CENTRE_OFFSET,
                  adc_fe_cal_pkg::OFS_CAP_MEASURE_WAIT_COUNT,
                  adc_fe_cal_pkg::OFS_TEMPERATURE_DIODE_TRIM, adc_fe_cal_pkg::OFS_REFERENCE_MONITOR_SEL};
        foreach (shadow[i]) shadow[i] = 8'h00;
        n = $urandom(32'hC2F1CFB1);
        repeat (20) @(posedge clk);
        #1 reset_n = 1'b1;
        foreach (addrs[i]) begin
            rd(addrs[i], got);
            chk("reset value", 8'h00, got);
        end
        check_outs();
        $display("test reset values done");
        // First pass all ones hits every reserved bit; later passes are random
        for (int p = 0; p < 4; p++) begin
            foreach (addrs[i]) begin
                d = (p == 0) ? 8'hFF : 8'($urandom);
                if (i == 6) d = 8'(125 + $urandom % 131);
                if (i == 7 && (shadow[8][3] ^ shadow[8][2])) d = 8'h03;
                if (i == 8 && (d[3] ^ d[2])) begin
                    wr(addrs[7], 8'h03);
                    shadow[7] = 8'h03;
                end
                wr(addrs[i], d);
                shadow[i] = d & mask_of(i);
                rd(addrs[i], got);
                chk("readback", shadow[i], got);
            end
            check_outs();
        end
        $display("test write readback done");
        wr(12'hBA3, 8'hFF);
        rd(12'hBA3, got);
        chk("unmapped", 8'h00, got);
        check_outs();
        $display("test unmapped done");
        for (int s = 0; s < 4; s++) begin
            shadow[7] = (s == 1 || s == 2) ? 8'h03 : 8'(s - 1);
            shadow[8] = {4'h0, 2'(s), 2'h1};
            if (shadow[7] == 8'h03) wr(addrs[7], shadow[7]);
            wr(addrs[8], shadow[8]);
            if (shadow[7] != 8'h03) wr(addrs[7], shadow[7]);
            check_outs();
        end
        $display("test monitor codes done");
        for (int k = 0; k < 4; k++) begin
            d = (k == 0) ? 8'h7D : (k == 1) ? 8'hFF : 8'(125 + $urandom % 131);
            wr(addrs[6], d);
            cap_reset = 1'b1;
            repeat (2) @(posedge clk);
            #1 chk("ramp held", 32'h1, ramp_clk);
            cap_reset = 1'b0;
            n = 0;
            do begin
                @(posedge clk) #1;
                n++;
                if (k == 3 && n == 40) cap_reset = 1'b1;
                if (k == 3 && n == 42) begin
                    chk("ramp aborted", 32'h1, ramp_clk);
                    cap_reset = 1'b0;
                end
            end while (ramp_clk === 1'b1 && n < 2100);
            // An abort restarts the count from the second fall, at cycle 43
            chk("ramp delay", 8 * d + ((k == 3) ? 43 : 1), n);
            cap_reset = 1'b0;
            @(posedge clk) #1;
        end
        $display("test ramp timing done");
        summarize();
    end
endmodule : adc_front_end_cal_config_regs_tb

`default_nettype wire
